// ===== design/osl_pkg.sv
// Purpose: Shared constants and types for the OTP lock-down and power-on block
// Assumes: Serial command opcodes are set here; single-byte commands end on a byte boundary
// Notes: Opcode values are plain defaults and may be changed to match the command set
package osl_pkg;
	// Command opcodes, shifted most significant bit first
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06; // write_enable_cmd
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // status_reg_write_cmd
	localparam logic [7:0] OP_SECURITY_WRITE = 8'h2F; // security_reg_write_cmd
	localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
	localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;

	// Bit counts on the link
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] BITS_ONE_BYTE = 5'h08;
	localparam logic [CNT_W-1:0] BITS_TWO_BYTES = 5'h10;
	localparam logic [CNT_W-1:0] BITS_FIRST = 5'h01;
	localparam logic [CNT_W-1:0] BITS_MAX = 5'h1F;

	// Security register layout
	localparam int SEC_FACTORY_BIT = 0;
	localparam int SEC_LOCK_BIT = 1;
	localparam logic [7:0] SEC_RESET = 8'h00;

	// Power-up select delay, in microseconds, and the system clock rate
	localparam int VSL_US_DEFAULT = 100;
	localparam int CLK_MHZ = 25;
	localparam int VSL_W = 24;

	// Power states, one-hot
	typedef enum logic [1:0] {
		ST_POR_WAIT = 2'b01,
		ST_STANDBY = 2'b10
	} osl_pwr_t;

	// Link-side state, clocked by the serial clock
	typedef struct packed {
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [CNT_W-1:0] bits;
	} osl_link_t;

	// System-side state
	typedef struct packed {
		osl_pwr_t pwr;
		logic [VSL_W-1:0] vsl_cnt;
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic strap_done;
		logic factory_lock;
		logic otp_lock;
		logic write_enable_latch;
		logic otp_mode;
		logic lock_nv_wr;
		logic status_wr;
		logic otp_prog_ok;
		logic otp_prog_refused;
	} osl_state_t;
endpackage

// ===== design/osl_top.sv
// Purpose: Security register lock-down command and power-on state of a serial flash
// Assumes: Chip select stays high for at least three system clocks between frames
// Notes: Link logic runs on the serial clock; results cross on the synchronised frame end
// How it works
// - Lock command works without write enable latch
// - Lock command changes only the lock bit
// - Locked OTP refuses every further program
// - Reject lock unless select rises after byte
// - Power up into standby, never deep power-down
// - Write enable latch clear at power-up
// - Reads accepted after power-up select delay
// - Bit0 factory lock, bit1 customer lock
// - No status or lock write in OTP mode
`timescale 1ns/10ps
module osl_top #(
	parameter int VSL_US = osl_pkg::VSL_US_DEFAULT
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic factory_lock_in,
	input wire logic lock_nv_in,
	output logic [7:0] sec_reg_out,
	output logic wel_out,
	output logic otp_mode_out,
	output logic standby_out,
	output logic read_ready_out,
	output logic lock_nv_wr_out,
	output logic status_wr_out,
	output logic otp_prog_ok_out,
	output logic otp_prog_refused_out
);
	import osl_pkg::*;

	// Whole cycles of the power-up select delay, exact as an integer product
	localparam int VSL_CYC = VSL_US * CLK_MHZ;
	localparam logic [VSL_W-1:0] VSL_LAST = VSL_W'(VSL_CYC - 1);

	osl_link_t lnk_q;
	osl_link_t lnk_d;
	logic in_frame_q;
	osl_state_t st_q;
	osl_state_t st_d;
	logic frame_end;
	logic exact_byte;
	logic ready;
	logic frame_tog_q;
	logic done_tog_q;
	logic fresh;

	// Frame marker; the select line itself ends the frame since the clock stops
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			in_frame_q <= 1'b0;
		end else begin
			in_frame_q <= 1'b1;
		end
	end

	// Shift in one bit per rising edge, MSB first; keep the first byte as opcode
	always_comb begin
		lnk_d = lnk_q;
		if (!in_frame_q) begin
			lnk_d.shift = {7'h00, si_in};
			lnk_d.bits = BITS_FIRST;
		end else begin
			lnk_d.shift = {lnk_q.shift[6:0], si_in};
			if (lnk_q.bits != BITS_MAX) begin
				lnk_d.bits = lnk_q.bits + BITS_FIRST;
			end
		end
		if (lnk_d.bits == BITS_ONE_BYTE) begin
			lnk_d.opcode = lnk_d.shift;
		end
	end

	always_ff @(posedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			lnk_q <= '0;
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// Flips on the first clock of every frame; a select pulse with no clocks leaves it alone
	always_ff @(posedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			frame_tog_q <= 1'b0;
		end else if (!in_frame_q) begin
			frame_tog_q <= !frame_tog_q;
		end
	end

	// Link words are quiet after select rises, so they are read on the synced edge
	assign frame_end = st_q.cs_sync && !st_q.cs_prev;
	assign exact_byte = lnk_q.bits == BITS_ONE_BYTE;
	assign ready = st_q.pwr == ST_STANDBY;

	// Remember the last frame acted on, so stale link words are never executed twice
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			done_tog_q <= 1'b0;
		end else if (frame_end) begin
			done_tog_q <= frame_tog_q;
		end
	end
	assign fresh = frame_tog_q != done_tog_q; // Only a clocked frame counts

	// System-side next state: power-up timing, straps and command execution
	always_comb begin
		st_d = st_q;
		st_d.cs_meta = cs_n_in;
		st_d.cs_sync = st_q.cs_meta;
		st_d.cs_prev = st_q.cs_sync;
		st_d.lock_nv_wr = 1'b0;
		st_d.status_wr = 1'b0;
		st_d.otp_prog_ok = 1'b0;
		st_d.otp_prog_refused = 1'b0;
		// Non-volatile bits are loaded once, the cycle after reset release
		if (!st_q.strap_done) begin
			st_d.strap_done = 1'b1;
			st_d.factory_lock = factory_lock_in;
			st_d.otp_lock = lock_nv_in;
		end
		unique case (st_q.pwr)
			ST_POR_WAIT: begin
				st_d.write_enable_latch = 1'b0;
				if (st_q.vsl_cnt == VSL_LAST) begin
					st_d.pwr = ST_STANDBY;
				end else begin
					st_d.vsl_cnt = st_q.vsl_cnt + VSL_W'(1);
				end
			end
			ST_STANDBY: begin
				// Commands before the select delay are dropped rather than half executed
				if (frame_end && fresh) begin
					if (exact_byte && lnk_q.opcode == OP_WRITE_ENABLE) begin
						st_d.write_enable_latch = 1'b1;
					end
					if (exact_byte && lnk_q.opcode == OP_WRITE_DISABLE) begin
						st_d.write_enable_latch = 1'b0;
					end
					if (exact_byte && lnk_q.opcode == OP_OTP_ENTER) begin
						st_d.otp_mode = 1'b1;
					end
					if (exact_byte && lnk_q.opcode == OP_OTP_EXIT) begin
						st_d.otp_mode = 1'b0;
					end
					// Lock needs no latch; only the lock bit can move, and only upward
					if (exact_byte && lnk_q.opcode == OP_SECURITY_WRITE && !st_q.otp_mode
						&& !st_q.otp_lock) begin
						st_d.otp_lock = 1'b1;
						st_d.lock_nv_wr = 1'b1;
					end
					if (lnk_q.bits == BITS_TWO_BYTES && lnk_q.opcode == OP_STATUS_WRITE) begin
						if (st_q.write_enable_latch && !st_q.otp_mode) begin
							st_d.status_wr = 1'b1;
						end
						st_d.write_enable_latch = 1'b0;
					end
					// OTP programming in OTP mode is refused once locked
					if (lnk_q.bits > BITS_ONE_BYTE && lnk_q.opcode == OP_PAGE_PROGRAM && st_q.otp_mode) begin
						if (st_q.write_enable_latch && !st_q.otp_lock) begin
							st_d.otp_prog_ok = 1'b1;
						end else begin
							st_d.otp_prog_refused = 1'b1;
						end
						st_d.write_enable_latch = 1'b0;
					end
				end
			end
		endcase
	end

	// Reset acts as the power-on reset: standby pending, latch clear
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '{pwr: ST_POR_WAIT, cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from state flip-flops
	always_comb begin
		sec_reg_out = SEC_RESET;
		sec_reg_out[SEC_FACTORY_BIT] = st_q.factory_lock;
		sec_reg_out[SEC_LOCK_BIT] = st_q.otp_lock;
	end
	assign wel_out = st_q.write_enable_latch;
	assign otp_mode_out = st_q.otp_mode;
	assign standby_out = ready;
	assign read_ready_out = ready;
	assign lock_nv_wr_out = st_q.lock_nv_wr;
	assign status_wr_out = st_q.status_wr;
	assign otp_prog_ok_out = st_q.otp_prog_ok;
	assign otp_prog_refused_out = st_q.otp_prog_refused;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence s_lock_cmd;
		frame_end && fresh && ready && exact_byte && lnk_q.opcode == OP_SECURITY_WRITE;
	endsequence

	a_lock_without_wel: assert property (s_lock_cmd ##0 (!st_q.otp_mode && st_q.strap_done) |=> st_q.otp_lock)
		else $error("lock not set");
	a_lock_only_bit: assert property (st_q.strap_done |=> $stable(st_q.factory_lock))
		else $error("factory bit moved");
	a_lock_sticky: assert property (st_q.otp_lock && st_q.strap_done |=> st_q.otp_lock)
		else $error("lock cleared");
	a_prog_refused: assert property (st_q.otp_lock |=> !st_q.otp_prog_ok)
		else $error("locked OTP programmed");
	a_lock_exact_byte: assert property (frame_end && !exact_byte && !st_q.otp_lock && st_q.strap_done
		|=> !st_q.otp_lock) else $error("lock on partial frame");
	a_no_replay: assert property (frame_end && !fresh && ready |=> $stable(st_q.write_enable_latch) && $stable(st_q.otp_mode))
		else $error("stale frame replayed");
	a_standby_after_vsl: assert property (st_q.pwr == ST_POR_WAIT && st_q.vsl_cnt == VSL_LAST
		|=> standby_out ##0 read_ready_out) else $error("standby late");
	a_wel_clear_pwrup: assert property (!ready |-> !wel_out ##1 (ready || !wel_out))
		else $error("latch set at power-up");
	a_read_gated: assert property (read_ready_out |-> st_q.vsl_cnt == VSL_LAST)
		else $error("read before delay");
	a_otp_mode_block: assert property (s_lock_cmd ##0 st_q.otp_mode
		|=> $stable(st_q.otp_lock) ##0 !lock_nv_wr_out) else $error("lock in OTP mode");
endmodule // osl_top

// ===== verif/osl_host.sv
// Purpose: Serial host model driving select, clock and data
// Assumes: Clock idles low and runs only inside frames
// Notes: Data shows the inverse of its last bit once released
`timescale 1ns/10ps
module osl_host (
	output logic sclk_out,
	output logic cs_n_out,
	output logic si_out
);
	// Deselected from time zero, so reset never sees a select
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end
	// One frame, first bit most significant, data set while clock is low
	task automatic frame(input logic [15:0] w, input int n);
		// Select falls clear of the system clock edge and stays low across at least one
		#5 cs_n_out = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			si_out = w[i];
			#24 sclk_out = 1'b1;
			#24 sclk_out = 1'b0;
		end
		#48 cs_n_out = 1'b1;
		si_out = ~si_out; // Released line must not look held
		#200;
	endtask
endmodule // osl_host

// ===== verif/osl_top_bench.sv
// Purpose: Self-checking bench for the OTP lock and power-on block
// Assumes: Select delay shortened to one microsecond
// Notes: Each frame's outcome is compared a few clocks after select rises
`timescale 1ns/10ps
module osl_top_bench;
	import osl_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic fac_in = 1'b0;
	logic lnv_in = 1'b0;
	logic fl = 1'b0;
	wire sclk, cs_n, si;
	logic [7:0] sec;
	logic write_enable_latch, otp, stby, rdy, lwr, swr, pok, pref;
	logic [3:0] seen = 4'h0;
	logic [15:0] exp_q[$];
	logic [31:0] rng = 32'h000106CF;
	int mismatches = 0;
	int check_count = 0;
	event res_ev;
	always #20 mclk_in = ~mclk_in;
	osl_host h_u (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si));
	osl_top #(.VSL_US(1)) dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.si_in(si), .factory_lock_in(fac_in), .lock_nv_in(lnv_in), .sec_reg_out(sec), .wel_out(write_enable_latch),
		.otp_mode_out(otp), .standby_out(stby), .read_ready_out(rdy), .lock_nv_wr_out(lwr),
		.status_wr_out(swr), .otp_prog_ok_out(pok), .otp_prog_refused_out(pref));
	// Pulses gathered over one frame, cleared while selected
	always @(posedge mclk_in) seen <= cs_n ? (seen | {lwr, swr, pok, pref}) : 4'h0;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [15:0] ex(input logic l, w, o, input logic [3:0] p);
		return {2'b11, 6'h00, l, fl, w, o, p};
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		check_count++;
		if (got !== want) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Result is read one step after the edge so that edge's updates have landed
	task automatic cmd(input logic [7:0] op, input int n, input logic [15:0] want);
		exp_q.push_back(want);
		h_u.frame({op, rng[15:8]}, n);
		repeat (3) @(posedge mclk_in);
		#1 -> res_ev;
		#1; // Lets the compare run before the next frame or the verdict
	endtask
	// Oldest note is taken whenever a result is due
	initial forever begin
		@(res_ev);
		check({stby, rdy, sec, write_enable_latch, otp, seen}, exp_q.pop_front());
	end
	// Hang guard, well beyond the roughly 21 microseconds the sequence needs
	initial begin
		#100000;
		mismatches++;
		conclude();
	end
	initial begin
		rng = xs(rng);
		@(posedge mclk_in);
		fac_in <= rng[0];
		fl <= rng[0];
		lnv_in <= 1'b0;
		repeat (16) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Early write enable is ignored and the latch stays clear
		cmd(OP_WRITE_ENABLE, 8, {2'b00, 7'h00, fl, 6'h00});
		for (int i = 0; i < 100 && !stby; i++) @(posedge mclk_in);
		cmd(OP_WRITE_DISABLE, 8, ex(0, 0, 0, 4'h0));
		cmd(OP_SECURITY_WRITE, 7, ex(0, 0, 0, 4'h0));
		cmd(OP_SECURITY_WRITE, 9, ex(0, 0, 0, 4'h0));
		cmd(OP_OTP_ENTER, 8, ex(0, 0, 1, 4'h0));
		cmd(OP_SECURITY_WRITE, 8, ex(0, 0, 1, 4'h0));
		cmd(OP_PAGE_PROGRAM, 16, ex(0, 0, 1, 4'h1));
		cmd(OP_WRITE_ENABLE, 8, ex(0, 1, 1, 4'h0));
		cmd(OP_PAGE_PROGRAM, 16, ex(0, 0, 1, 4'h2));
		// Select pulse with no clocks must not replay the program just done
		cmd(OP_PAGE_PROGRAM, 0, ex(0, 0, 1, 4'h0));
		cmd(OP_OTP_EXIT, 8, ex(0, 0, 0, 4'h0));
		// Status write: dropped without the latch, taken with it, latch cleared either way
		cmd(OP_STATUS_WRITE, 16, ex(0, 0, 0, 4'h0));
		cmd(OP_WRITE_ENABLE, 8, ex(0, 1, 0, 4'h0));
		cmd(OP_STATUS_WRITE, 16, ex(0, 0, 0, 4'h4));
		// Lock with the latch clear, then lock again, then try to program
		cmd(OP_SECURITY_WRITE, 8, ex(1, 0, 0, 4'h8));
		cmd(OP_SECURITY_WRITE, 8, ex(1, 0, 0, 4'h0));
		cmd(OP_WRITE_ENABLE, 8, ex(1, 1, 0, 4'h0));
		cmd(OP_OTP_ENTER, 8, ex(1, 1, 1, 4'h0));
		cmd(OP_STATUS_WRITE, 16, ex(1, 0, 1, 4'h0));
		cmd(OP_WRITE_ENABLE, 8, ex(1, 1, 1, 4'h0));
		cmd(OP_PAGE_PROGRAM, 16, ex(1, 0, 1, 4'h1));
		// Power cycle with the latch set: latch and mode come back clear, lock reloads
		cmd(OP_WRITE_ENABLE, 8, ex(1, 1, 1, 4'h0));
		@(posedge mclk_in);
		exp_q.push_back({2'b00, 6'h00, 1'b1, fl, 6'h00});
		lnv_in <= 1'b1;
		rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		#1 -> res_ev;
		#1;
		for (int i = 0; i < 100 && !stby; i++) @(posedge mclk_in);
		cmd(OP_SECURITY_WRITE, 8, ex(1, 0, 0, 4'h0));
		conclude();
	end
endmodule // osl_top_bench
